// [pkg/atc_pkg.sv]
/*
  Package for the acquisition trigger control block: register map,
  field positions, reset values, encodings and timing constants.
  Assumes a 32-bit APB slave clocked by pclk at 50 MHz.
*/
package atc_pkg;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] ATC_OFF_CTRL = 8'h00;
  localparam logic [7:0] ATC_OFF_CMD = 8'h04;
  localparam logic [7:0] ATC_OFF_EXPT = 8'h08;
  localparam logic [7:0] ATC_OFF_PERIOD = 8'h0c;
  localparam logic [7:0] ATC_OFF_COUNT = 8'h10;
  localparam logic [7:0] ATC_OFF_STATUS = 8'h14;
  localparam logic [7:0] ATC_OFF_MINPER = 8'h18;

  // ----------------------------------------
  // Control field positions
  // ----------------------------------------
  localparam int ATC_CTRL_MODE_LSB = 0;
  localparam int ATC_CTRL_TRIGON_BIT = 2;
  localparam int ATC_CTRL_SRC_LSB = 4;
  localparam int ATC_CTRL_RISE_BIT = 8;
  localparam int ATC_CTRL_WIDTH_BIT = 9;
  localparam int ATC_CTRL_USEROUT_BIT = 12;

  // Command bits (write one to execute)
  localparam int ATC_CMD_START_BIT = 0;
  localparam int ATC_CMD_STOP_BIT = 1;
  localparam int ATC_CMD_SWTRIG_BIT = 2;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [31:0] ATC_CTRL_RST = 32'h0000_0100;
  localparam logic [31:0] ATC_EXPT_RST = 32'h0000_03e8;
  localparam logic [31:0] ATC_PERIOD_RST = 32'h0000_2710;
  localparam logic [15:0] ATC_COUNT_RST = 16'h0001;
  localparam logic [31:0] ATC_MINPER_RST = 32'h0000_0400;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int ATC_CLK_MHZ = 50;
  localparam int ATC_READOUT_NS = 200;
  localparam int ATC_READOUT_CYC = (ATC_READOUT_NS * ATC_CLK_MHZ + 999) / 1000;

  // ----------------------------------------
  // Enumerations
  // ----------------------------------------
  typedef enum logic [1:0] {
    ATC_MODE_CONT = 2'h0,
    ATC_MODE_ONE = 2'h1,
    ATC_MODE_BURST = 2'h2
  } atc_mode_t;

  typedef enum logic [2:0] {
    ATC_SRC_SW = 3'h0,
    ATC_SRC_USER = 3'h1,
    ATC_SRC_LINK = 3'h2,
    ATC_SRC_TIMER = 3'h3,
    ATC_SRC_LINE = 3'h4
  } atc_src_t;

  // Gray codes along idle, wait, expose, readout
  typedef enum logic [1:0] {
    ATC_ST_IDLE = 2'b00,
    ATC_ST_WAIT = 2'b01,
    ATC_ST_EXPOSE = 2'b11,
    ATC_ST_READ = 2'b10
  } atc_state_t;

  // Configuration carrier
  typedef struct packed {
    logic user_out;
    logic width_mode;
    logic rise;
    atc_src_t src;
    logic trig_on;
    atc_mode_t mode;
  } atc_cfg_t;

endpackage

// [rtl/atc_core.sv]
/*
  Acquisition trigger control: arms and disarms acquisition, runs the
  free-run generator or accepts one selected trigger source, and times
  exposure and readout. APB slave for all settings.
  Assumes external pins are asynchronous to pclk; the link and timer
  trigger inputs come from logic already on pclk.
*/
`timescale 1ns/1ps

module atc_core (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Trigger sources
  input wire logic coax_link_trigger_source,
  input wire logic timer_output_source,
  input wire logic external_input_line,
  // Sensor side
  output logic exposing,
  output logic reading,
  output logic frame_start,
  output logic armed
);

  // ----------------------------------------
  // Registers and decode
  // ----------------------------------------
  atc_pkg::atc_cfg_t cfg_r;
  logic [31:0] expt_r;
  logic [31:0] period_r;
  logic [15:0] multi_frame_target;
  logic [31:0] minper_r;
  atc_pkg::atc_state_t st_r;
  atc_pkg::atc_state_t st_nxt;
  logic armed_r;
  logic stop_pend_r;
  logic [15:0] frames_r;
  logic [31:0] exp_cnt_r;
  logic [31:0] fr_cnt_r;
  logic [7:0] rd_cnt_r;
  logic [2:0] line_sync_r;
  logic line_prev_r;
  logic link_prev_r;
  logic timer_prev_r;
  logic user_prev_r;
  logic [31:0] prdata_r;
  logic exposing_r;
  logic reading_r;
  logic frame_start_r;

  // Reset settings unpacked by bus position, as for writes
  localparam atc_pkg::atc_cfg_t CFG_RST = '{
    user_out: atc_pkg::ATC_CTRL_RST[atc_pkg::ATC_CTRL_USEROUT_BIT],
    width_mode: atc_pkg::ATC_CTRL_RST[atc_pkg::ATC_CTRL_WIDTH_BIT],
    rise: atc_pkg::ATC_CTRL_RST[atc_pkg::ATC_CTRL_RISE_BIT],
    src: atc_pkg::atc_src_t'(atc_pkg::ATC_CTRL_RST[atc_pkg::ATC_CTRL_SRC_LSB +: 3]),
    trig_on: atc_pkg::ATC_CTRL_RST[atc_pkg::ATC_CTRL_TRIGON_BIT],
    mode: atc_pkg::atc_mode_t'(atc_pkg::ATC_CTRL_RST[atc_pkg::ATC_CTRL_MODE_LSB +: 2])
  };

  wire wr_en = psel && penable && pwrite;
  wire rd_setup = psel && !penable && !pwrite; // Read data latched in setup
  wire hit_ctrl = paddr == atc_pkg::ATC_OFF_CTRL;
  wire hit_cmd = paddr == atc_pkg::ATC_OFF_CMD;
  wire hit_expt = paddr == atc_pkg::ATC_OFF_EXPT;
  wire hit_per = paddr == atc_pkg::ATC_OFF_PERIOD;
  wire hit_cnt = paddr == atc_pkg::ATC_OFF_COUNT;
  wire hit_stat = paddr == atc_pkg::ATC_OFF_STATUS;
  wire hit_min = paddr == atc_pkg::ATC_OFF_MINPER;
  wire cmd_wr = wr_en && hit_cmd;
  wire start_cmd = cmd_wr && pwdata[atc_pkg::ATC_CMD_START_BIT];
  wire stop_cmd = cmd_wr && pwdata[atc_pkg::ATC_CMD_STOP_BIT];
  wire sw_cmd = cmd_wr && pwdata[atc_pkg::ATC_CMD_SWTRIG_BIT];

  // Control fields taken by bit position; the carrier is packed tighter
  // than the bus word, so a plain cast would scramble the fields
  wire [1:0] wr_mode = pwdata[atc_pkg::ATC_CTRL_MODE_LSB +: 2];
  wire [2:0] wr_src = pwdata[atc_pkg::ATC_CTRL_SRC_LSB +: 3];
  wire atc_pkg::atc_cfg_t wr_cfg = '{
    user_out: pwdata[atc_pkg::ATC_CTRL_USEROUT_BIT],
    width_mode: pwdata[atc_pkg::ATC_CTRL_WIDTH_BIT],
    rise: pwdata[atc_pkg::ATC_CTRL_RISE_BIT],
    src: atc_pkg::atc_src_t'(wr_src),
    trig_on: pwdata[atc_pkg::ATC_CTRL_TRIGON_BIT],
    mode: atc_pkg::atc_mode_t'(wr_mode)
  };

  // ----------------------------------------
  // Source selection and edge detect
  // ----------------------------------------
  // Line settled once second and third stages agree
  wire line_now = (line_sync_r[1] == line_sync_r[2]) ? line_sync_r[2] : line_prev_r;
  logic src_lvl;
  logic src_prev;
  always_comb begin
    src_lvl = 1'b0;
    src_prev = 1'b0;
    case (cfg_r.src)
      atc_pkg::ATC_SRC_USER: begin
        src_lvl = cfg_r.user_out;
        src_prev = user_prev_r;
      end
      atc_pkg::ATC_SRC_LINK: begin
        src_lvl = coax_link_trigger_source;
        src_prev = link_prev_r;
      end
      atc_pkg::ATC_SRC_TIMER: begin
        src_lvl = timer_output_source;
        src_prev = timer_prev_r;
      end
      atc_pkg::ATC_SRC_LINE: begin
        src_lvl = line_now;
        src_prev = line_prev_r;
      end
      default: begin
        src_lvl = 1'b0;
        src_prev = 1'b0;
      end
    endcase
  end

  // Active polarity set by activation bit
  wire act_lvl = cfg_r.rise ? src_lvl : !src_lvl;
  wire act_prev = cfg_r.rise ? src_prev : !src_prev;
  wire hw_edge = act_lvl && !act_prev;
  wire hw_end = !act_lvl && act_prev;
  wire is_sw = cfg_r.src == atc_pkg::ATC_SRC_SW;
  // Software source is always timed; width mode only for pin-like sources
  wire width_on = cfg_r.trig_on && cfg_r.width_mode && !is_sw;

  // Free-run period never shorter than the minimum period
  wire [31:0] eff_per = (period_r < minper_r) ? minper_r : period_r;
  wire fr_tick = fr_cnt_r >= eff_per - 32'h1;
  // Only exposure-start trigger exists; one selected source at a time
  wire trig = cfg_r.trig_on ? (is_sw ? sw_cmd : hw_edge) : fr_tick;

  wire in_wait = st_r == atc_pkg::ATC_ST_WAIT;
  wire accept = in_wait && trig && !stop_cmd;
  wire exp_done = width_on ? hw_end : (exp_cnt_r <= 32'h1);
  wire rd_done = rd_cnt_r == 8'h1;
  wire last_frame = (cfg_r.mode == atc_pkg::ATC_MODE_ONE) ||
                    (cfg_r.mode == atc_pkg::ATC_MODE_BURST &&
                     frames_r + 16'h1 >= multi_frame_target);
  wire stop_now = stop_pend_r || stop_cmd;

  // ----------------------------------------
  // Acquisition state machine
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      atc_pkg::ATC_ST_IDLE: begin
        if (start_cmd) begin
          st_nxt = atc_pkg::ATC_ST_WAIT;
        end
      end
      atc_pkg::ATC_ST_WAIT: begin
        if (stop_cmd) begin
          st_nxt = atc_pkg::ATC_ST_IDLE;
        end else if (accept) begin
          st_nxt = atc_pkg::ATC_ST_EXPOSE;
        end
      end
      atc_pkg::ATC_ST_EXPOSE: begin
        if (exp_done) begin
          st_nxt = atc_pkg::ATC_ST_READ;
        end
      end
      atc_pkg::ATC_ST_READ: begin
        if (rd_done) begin
          // Finish the frame, then stop or rearm on our own
          st_nxt = (stop_now || last_frame) ? atc_pkg::ATC_ST_IDLE
                                            : atc_pkg::ATC_ST_WAIT;
        end
      end
      default: st_nxt = atc_pkg::ATC_ST_IDLE;
    endcase
  end

  // State, arming and frame count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= atc_pkg::ATC_ST_IDLE;
      armed_r <= 1'b0;
      stop_pend_r <= 1'b0;
      frames_r <= 16'h0;
    end else begin
      st_r <= st_nxt;
      armed_r <= st_nxt != atc_pkg::ATC_ST_IDLE;
      // Stop during a frame is held until that frame ends
      stop_pend_r <= (st_nxt == atc_pkg::ATC_ST_IDLE) ? 1'b0 : (stop_pend_r | stop_cmd);
      if (st_r == atc_pkg::ATC_ST_IDLE && start_cmd) begin
        frames_r <= 16'h0;
      end else if (st_r == atc_pkg::ATC_ST_READ && rd_done) begin
        frames_r <= frames_r + 16'h1;
      end
    end
  end

  // Exposure, readout and free-run counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exp_cnt_r <= 32'h0;
      rd_cnt_r <= 8'h0;
      fr_cnt_r <= 32'h0;
    end else begin
      exp_cnt_r <= accept ? expt_r : (exp_cnt_r != 32'h0 ? exp_cnt_r - 32'h1 : 32'h0);
      rd_cnt_r <= (st_r == atc_pkg::ATC_ST_EXPOSE && exp_done) ?
                  8'(atc_pkg::ATC_READOUT_CYC) :
                  (rd_cnt_r != 8'h0 ? rd_cnt_r - 8'h1 : 8'h0);
      // Counts from each start so the rate is kept between frames
      fr_cnt_r <= (!armed_r || fr_tick) ? 32'h0 : fr_cnt_r + 32'h1;
    end
  end

  // Input synchroniser and previous levels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_sync_r <= 3'h0;
      line_prev_r <= 1'b0;
      link_prev_r <= 1'b0;
      timer_prev_r <= 1'b0;
      user_prev_r <= 1'b0;
    end else begin
      line_sync_r <= {line_sync_r[1:0], external_input_line};
      line_prev_r <= line_now;
      link_prev_r <= coax_link_trigger_source;
      timer_prev_r <= timer_output_source;
      user_prev_r <= cfg_r.user_out;
    end
  end

  // Registered outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exposing_r <= 1'b0;
      reading_r <= 1'b0;
      frame_start_r <= 1'b0;
    end else begin
      exposing_r <= st_nxt == atc_pkg::ATC_ST_EXPOSE;
      reading_r <= st_nxt == atc_pkg::ATC_ST_READ;
      frame_start_r <= accept;
    end
  end

  // ----------------------------------------
  // APB register file
  // ----------------------------------------
  wire [31:0] stat_word = {12'h0, frames_r, stop_pend_r, armed_r, 2'(st_r)};
  // Fields put back at their bus positions for readback
  wire [31:0] ctrl_word = (32'(cfg_r.mode) << atc_pkg::ATC_CTRL_MODE_LSB) |
                          (32'(cfg_r.trig_on) << atc_pkg::ATC_CTRL_TRIGON_BIT) |
                          (32'(cfg_r.src) << atc_pkg::ATC_CTRL_SRC_LSB) |
                          (32'(cfg_r.rise) << atc_pkg::ATC_CTRL_RISE_BIT) |
                          (32'(cfg_r.width_mode) << atc_pkg::ATC_CTRL_WIDTH_BIT) |
                          (32'(cfg_r.user_out) << atc_pkg::ATC_CTRL_USEROUT_BIT);
  wire [31:0] rd_mux = hit_ctrl ? ctrl_word :
                       hit_expt ? expt_r :
                       hit_per ? period_r :
                       hit_cnt ? {16'h0, multi_frame_target} :
                       hit_stat ? stat_word :
                       hit_min ? minper_r : 32'h0;

  // Writes take effect at the access edge; zero-wait answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= CFG_RST;
      expt_r <= atc_pkg::ATC_EXPT_RST;
      period_r <= atc_pkg::ATC_PERIOD_RST;
      multi_frame_target <= atc_pkg::ATC_COUNT_RST;
      minper_r <= atc_pkg::ATC_MINPER_RST;
      prdata_r <= 32'h0;
    end else begin
      if (wr_en && hit_ctrl) begin
        cfg_r <= wr_cfg;
      end
      if (wr_en && hit_expt) begin
        expt_r <= pwdata;
      end
      if (wr_en && hit_per) begin
        period_r <= pwdata;
      end
      if (wr_en && hit_cnt) begin
        multi_frame_target <= pwdata[15:0];
      end
      if (wr_en && hit_min) begin
        minper_r <= pwdata;
      end
      prdata_r <= rd_setup ? rd_mux : prdata_r;
    end
  end

  assign prdata = prdata_r;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign exposing = exposing_r;
  assign reading = reading_r;
  assign frame_start = frame_start_r;
  assign armed = armed_r;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence s_exp_end;
    st_r == atc_pkg::ATC_ST_READ && rd_done;
  endsequence

  a_idle_no_frame: assert property (@(posedge pclk) disable iff (!presetn)
    st_r == atc_pkg::ATC_ST_IDLE && !start_cmd |=> !exposing_r)
    else $error("Exposure without start");
  a_stop_disarms: assert property (@(posedge pclk) disable iff (!presetn)
    in_wait && stop_cmd |=> st_r == atc_pkg::ATC_ST_IDLE)
    else $error("Stop did not disarm");
  a_single_stops: assert property (@(posedge pclk) disable iff (!presetn)
    s_exp_end and (cfg_r.mode == atc_pkg::ATC_MODE_ONE) |=> !armed_r)
    else $error("Single frame did not stop");
  a_stop_finishes: assert property (@(posedge pclk) disable iff (!presetn)
    st_r == atc_pkg::ATC_ST_EXPOSE && stop_cmd |=> st_r != atc_pkg::ATC_ST_IDLE)
    else $error("Stop cut frame short");
  a_accept_exposes: assert property (@(posedge pclk) disable iff (!presetn)
    accept && !stop_cmd |=> exposing_r && frame_start_r)
    else $error("Trigger not accepted");
  a_busy_ignores: assert property (@(posedge pclk) disable iff (!presetn)
    st_r == atc_pkg::ATC_ST_READ && !rd_done |=> !frame_start_r)
    else $error("Busy trigger accepted");
  a_cont_rearms: assert property (@(posedge pclk) disable iff (!presetn)
    s_exp_end and (cfg_r.mode == atc_pkg::ATC_MODE_CONT) and !stop_now |=> in_wait)
    else $error("No automatic rearm");
  a_timed_length: assert property (@(posedge pclk) disable iff (!presetn)
    accept && !width_on && expt_r == 32'h5 |=> exposing_r [*5] ##1 !exposing_r)
    else $error("Timed exposure length wrong");
  a_burst_stops: assert property (@(posedge pclk) disable iff (!presetn)
    s_exp_end and (cfg_r.mode == atc_pkg::ATC_MODE_BURST) and
    (frames_r + 16'h1 == multi_frame_target) |=> !armed_r)
    else $error("Burst did not stop at target");
  a_width_ends: assert property (@(posedge pclk) disable iff (!presetn)
    st_r == atc_pkg::ATC_ST_EXPOSE && width_on && hw_end |=> !exposing_r)
    else $error("Pulse-width exposure did not end");
  a_pend_stops: assert property (@(posedge pclk) disable iff (!presetn)
    s_exp_end and (stop_pend_r == 1'b1) |=> st_r == atc_pkg::ATC_ST_IDLE)
    else $error("Pending stop not applied");

endmodule

// [testbench/acquisition_trigger_control_tb.sv]
/*
  Self-checking bench for the acquisition trigger control block.
  Assumes a zero-wait APB slave and the source model beside it.
*/
`timescale 1ns/1ps

module acquisition_trigger_control_tb;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic link_trig;
  logic timer_act;
  logic line_in;
  logic exposing;
  logic reading;
  logic frame_start;
  logic armed;
  logic [31:0] rd;
  int bad_count = 0;
  int n_tests = 0;
  int fs_n = 0;
  int ex_n = 0;

  // Clock at 50 MHz
  always #10 pclk = ~pclk;

  atc_core dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .coax_link_trigger_source(link_trig),
    .timer_output_source(timer_act), .external_input_line(line_in),
    .exposing(exposing), .reading(reading), .frame_start(frame_start), .armed(armed));

  atc_src_model src_u (.pclk(pclk), .link_trig(link_trig), .timer_act(timer_act),
    .line_in(line_in));

  // Frame and exposure-cycle tallies
  always @(posedge pclk) begin
    if (frame_start === 1'b1) fs_n++;
    if (exposing === 1'b1) ex_n++;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Request held until pready is seen high in the access phase
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cmd(input int b);
    apb(1'b1, atc_pkg::ATC_OFF_CMD, 32'h1 << b);
  endtask

  function automatic logic [31:0] cfg(input logic [1:0] m, input logic t,
    input logic [2:0] s, input logic r, input logic w, input logic u);
    cfg = 32'h0;
    cfg[atc_pkg::ATC_CTRL_MODE_LSB +: 2] = m;
    cfg[atc_pkg::ATC_CTRL_TRIGON_BIT] = t;
    cfg[atc_pkg::ATC_CTRL_SRC_LSB +: 3] = s;
    cfg[atc_pkg::ATC_CTRL_RISE_BIT] = r;
    cfg[atc_pkg::ATC_CTRL_WIDTH_BIT] = w;
    cfg[atc_pkg::ATC_CTRL_USEROUT_BIT] = u;
  endfunction

  // Bounded wait for the automatic or commanded stop
  task automatic wait_idle();
    for (int i = 0; i < 3000 && armed !== 1'b0; i++) @(posedge pclk);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk({31'h0, armed}, 32'h0);
    chk({30'h0, pready, pslverr}, 32'h2);
    apb(1'b0, atc_pkg::ATC_OFF_STATUS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, atc_pkg::ATC_OFF_CTRL, 32'h0);
    chk(rd, atc_pkg::ATC_CTRL_RST);
    apb(1'b0, 8'h1c, 32'h0);
    chk(rd, 32'h0);
  endtask

  // Software trigger without start, then one-shot with a busy retrigger
  task automatic t_single();
    apb(1'b1, atc_pkg::ATC_OFF_CTRL, cfg(atc_pkg::ATC_MODE_ONE, 1'b1, atc_pkg::ATC_SRC_SW,
      1'b1, 1'b0, 1'b0));
    apb(1'b1, atc_pkg::ATC_OFF_EXPT, 32'h5);
    fs_n = 0;
    cmd(atc_pkg::ATC_CMD_SWTRIG_BIT);
    repeat (30) @(posedge pclk);
    chk(fs_n, 32'h0);
    cmd(atc_pkg::ATC_CMD_START_BIT);
    apb(1'b0, atc_pkg::ATC_OFF_STATUS, 32'h0);
    chk(rd[1:0], 32'h1);
    ex_n = 0;
    cmd(atc_pkg::ATC_CMD_SWTRIG_BIT);
    cmd(atc_pkg::ATC_CMD_SWTRIG_BIT);
    wait_idle();
    chk(fs_n, 32'h1);
    chk(ex_n, 32'h5);
    cmd(atc_pkg::ATC_CMD_SWTRIG_BIT);
    repeat (30) @(posedge pclk);
    chk(fs_n, 32'h1);
  endtask

  // Counted burst of two from the link, a retrigger lands while busy
  task automatic t_burst();
    apb(1'b1, atc_pkg::ATC_OFF_CTRL, cfg(atc_pkg::ATC_MODE_BURST, 1'b1,
      atc_pkg::ATC_SRC_LINK, 1'b1, 1'b0, 1'b0));
    apb(1'b1, atc_pkg::ATC_OFF_COUNT, 32'h2);
    fs_n = 0;
    cmd(atc_pkg::ATC_CMD_START_BIT);
    src_u.pulse(0, 1'b1, 3);
    src_u.pulse(0, 1'b1, 3);
    repeat (30) @(posedge pclk);
    src_u.pulse(0, 1'b1, 3);
    repeat (30) @(posedge pclk);
    src_u.pulse(0, 1'b1, 3);
    repeat (30) @(posedge pclk);
    chk(fs_n, 32'h2);
    chk({31'h0, armed}, 32'h0);
  endtask

  // Free-run rate, clamped by the minimum period; stop lands mid-exposure
  task automatic t_rate(input logic [31:0] per, input logic [31:0] minp);
    logic seen;
    seen = 1'b0;
    apb(1'b1, atc_pkg::ATC_OFF_CTRL, cfg(atc_pkg::ATC_MODE_CONT, 1'b0, atc_pkg::ATC_SRC_SW,
      1'b1, 1'b0, 1'b0));
    apb(1'b1, atc_pkg::ATC_OFF_PERIOD, per);
    apb(1'b1, atc_pkg::ATC_OFF_MINPER, minp);
    fs_n = 0;
    cmd(atc_pkg::ATC_CMD_START_BIT);
    repeat (400) @(posedge pclk);
    chk({31'h0, fs_n inside {[9:11]}}, 32'h1);
    for (int i = 0; i < 100 && exposing !== 1'b1; i++) @(posedge pclk);
    cmd(atc_pkg::ATC_CMD_STOP_BIT);
    for (int i = 0; i < 20 && !seen; i++) begin
      @(posedge pclk);
      seen = (reading === 1'b1);
    end
    chk({31'h0, seen}, 32'h1);
    wait_idle();
    fs_n = 0;
    repeat (100) @(posedge pclk);
    chk(fs_n, 32'h0);
  endtask

  // Pulse-width exposure on the line (falling active) and timer sources
  task automatic t_width();
    src_u.set(2, 1'b1);
    apb(1'b1, atc_pkg::ATC_OFF_CTRL, cfg(atc_pkg::ATC_MODE_ONE, 1'b1,
      atc_pkg::ATC_SRC_LINE, 1'b0, 1'b1, 1'b0));
    cmd(atc_pkg::ATC_CMD_START_BIT);
    ex_n = 0;
    src_u.pulse(2, 1'b0, 30);
    wait_idle();
    chk({31'h0, ex_n inside {[29:32]}}, 32'h1);
    apb(1'b1, atc_pkg::ATC_OFF_CTRL, cfg(atc_pkg::ATC_MODE_ONE, 1'b1,
      atc_pkg::ATC_SRC_TIMER, 1'b1, 1'b1, 1'b0));
    cmd(atc_pkg::ATC_CMD_START_BIT);
    ex_n = 0;
    src_u.pulse(1, 1'b1, 8);
    wait_idle();
    chk({31'h0, ex_n inside {[7:10]}}, 32'h1);
  endtask

  // Host toggle of the user output bit forms the trigger
  task automatic t_user();
    apb(1'b1, atc_pkg::ATC_OFF_CTRL, cfg(atc_pkg::ATC_MODE_ONE, 1'b1,
      atc_pkg::ATC_SRC_USER, 1'b1, 1'b0, 1'b0));
    cmd(atc_pkg::ATC_CMD_START_BIT);
    fs_n = 0;
    apb(1'b1, atc_pkg::ATC_OFF_CTRL, cfg(atc_pkg::ATC_MODE_ONE, 1'b1,
      atc_pkg::ATC_SRC_USER, 1'b1, 1'b0, 1'b1));
    wait_idle();
    chk(fs_n, 32'h1);
    apb(1'b0, atc_pkg::ATC_OFF_CTRL, 32'h0);
    chk(rd, cfg(atc_pkg::ATC_MODE_ONE, 1'b1, atc_pkg::ATC_SRC_USER, 1'b1, 1'b0, 1'b1));
  endtask

  // ----------------------------------------
  // Sequence, verdict and watchdog
  // ----------------------------------------
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Reset held three cycles, then each scenario in turn
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_single();
    t_burst();
    t_rate(32'd40, 32'd20);
    t_rate(32'd5, 32'd40);
    t_width();
    t_user();
    conclude();
  end

  // Scenarios need about 1600 cycles; allow 25 times that
  initial begin
    #800000;
    bad_count++;
    conclude();
  end
endmodule

// [testbench/atc_src_model.sv]
/*
  Far-side trigger sources: link trigger, timer output and external line.
  Assumes the bench calls pulse and set just after rising edges of pclk.
*/
`timescale 1ns/1ps

module atc_src_model (
  // Clock
  input wire logic pclk,
  // Source levels toward the block
  output logic link_trig,
  output logic timer_act,
  output logic line_in
);
  // ----------------------------------------
  // Source drivers
  // ----------------------------------------
  initial begin
    link_trig = 1'b0;
    timer_act = 1'b0;
    line_in = 1'b0;
  end

  // Levels change only by non-blocking update after an edge
  task automatic set(input int sel, input logic v);
    if (sel == 0) link_trig <= v;
    else if (sel == 1) timer_act <= v;
    else line_in <= v;
  endtask

  // Active level for w cycles, then a gap so the rate stays legal
  task automatic pulse(input int sel, input logic v, input int w);
    set(sel, v);
    repeat (w) @(posedge pclk);
    set(sel, ~v);
    repeat (4) @(posedge pclk);
  endtask
endmodule
